// file: hw/shcs_pkg.sv
// package for the serial host command server: command codes, area
// numbering, memory geometry and the carrier structs.
// assumes a single clock domain; nothing here holds state.
package shcs_pkg;

	// two-letter header codes, ascii, first letter in the high byte
	localparam logic [15:0] CODE_READ_CORE_IO_WORDS    = 16'h5252;
	localparam logic [15:0] CODE_READ_LINK_WORDS       = 16'h524C;
	localparam logic [15:0] CODE_READ_HOLDING_WORDS    = 16'h5248;
	localparam logic [15:0] CODE_READ_PRESENT_VALUES   = 16'h5243;
	localparam logic [15:0] CODE_READ_COMPLETION_FLAGS = 16'h5247;
	localparam logic [15:0] CODE_READ_DATA_WORDS       = 16'h5244;
	localparam logic [15:0] CODE_READ_AUXILIARY_WORDS  = 16'h524A;

	// memory area numbers
	localparam logic [2:0] AREA_CORE_IO   = 3'h0;
	localparam logic [2:0] AREA_LINK      = 3'h1;
	localparam logic [2:0] AREA_HOLDING   = 3'h2;
	localparam logic [2:0] AREA_PRESENT   = 3'h3;
	localparam logic [2:0] AREA_FLAGS     = 3'h4;
	localparam logic [2:0] AREA_DATA      = 3'h5;
	localparam logic [2:0] AREA_AUXILIARY = 3'h6;
	localparam logic [2:0] AREA_NONE      = 3'h7;

	// geometry: 64 words per area, 16-bit words
	localparam int          WORD_BITS   = 16;
	localparam int          INDEX_BITS  = 6;
	localparam int          ADDR_BITS   = 9;
	localparam int          BANK_WORDS  = 448;
	localparam logic [16:0] AREA_DEPTH  = 17'h00040;
	localparam logic [15:0] ERROR_WORD  = 16'h0000;
	localparam logic [7:0]  COUNT_ONE   = 8'h01;

	// read command from the frame parser
	typedef struct packed {
		logic [15:0] code;
		logic [15:0] start;
		logic [7:0]  count;
	} shcs_cmd_type;

	// one response word toward the frame builder
	typedef struct packed {
		logic [15:0] data;
		logic        last;
		logic        error;
	} shcs_rsp_type;

	// write port used by the controller core to fill the areas
	typedef struct packed {
		logic [2:0]  area;
		logic [5:0]  index;
		logic [15:0] data;
	} shcs_mem_wr_type;

	// header code to area number, AREA_NONE when unknown
	function automatic logic [2:0] shcs_area_of(input logic [15:0] code);
		case (code)
			CODE_READ_CORE_IO_WORDS:    return AREA_CORE_IO;
			CODE_READ_LINK_WORDS:       return AREA_LINK;
			CODE_READ_HOLDING_WORDS:    return AREA_HOLDING;
			CODE_READ_PRESENT_VALUES:   return AREA_PRESENT;
			CODE_READ_COMPLETION_FLAGS: return AREA_FLAGS;
			CODE_READ_DATA_WORDS:       return AREA_DATA;
			CODE_READ_AUXILIARY_WORDS:  return AREA_AUXILIARY;
			default:                    return AREA_NONE;
		endcase
	endfunction : shcs_area_of

	// flat word address of an area word, used by read and write side
	function automatic logic [8:0] shcs_word_addr(input logic [2:0] area,
		input logic [5:0] index);
		return {area, index};
	endfunction : shcs_word_addr

endpackage : shcs_pkg

// file: hw/shcs_word_bank.sv
// word bank holding all seven memory areas in one array.
// one write port, one read port with a single cycle of latency.
`timescale 1ns/1ps
module shcs_word_bank
	import shcs_pkg::*;
(
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 resetn,
	// write side
	input  wire logic                 wr_en,
	input  wire logic [ADDR_BITS-1:0] wr_addr,
	input  wire logic [WORD_BITS-1:0] wr_data,
	// read side
	input  wire logic [ADDR_BITS-1:0] rd_addr,
	output logic      [WORD_BITS-1:0] rd_data
);

	logic [WORD_BITS-1:0] words [BANK_WORDS];
	logic [WORD_BITS-1:0] next_rd_data;

	// read is unconditional; the caller picks the cycle that matters
	always_comb
	begin
		next_rd_data = words[rd_addr];
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rd_data <= 16'h0000;
		else
			rd_data <= next_rd_data;
	end

	// array has no reset, so it maps onto plain ram
	always_ff @(posedge clk)
	begin
		if (wr_en)
			words[wr_addr] <= wr_data;
	end

endmodule : shcs_word_bank

// file: hw/shcs_server.sv
// serial host command server: answers two-letter read commands with
// a stream of words taken from the selected memory area.
// assumes a frame parser on the same clock hands in decoded commands
// and a frame builder drains the response words with valid/ready.
`timescale 1ns/1ps
module shcs_server
	import shcs_pkg::*;
(
	// clock and reset
	input  wire logic            CLK_SYS,
	input  wire logic            RESETN,
	// command from frame parser
	input  wire logic            CMD_VALID,
	output logic                 CMD_READY,
	input  wire shcs_cmd_type    CMD,
	// response words to frame builder
	output logic                 RSP_VALID,
	input  wire logic            RSP_READY,
	output shcs_rsp_type         RSP,
	// area fill from the controller core
	input  wire logic            MEM_WR_EN,
	input  wire shcs_mem_wr_type MEM_WR
);

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_FETCH = 4'b0010,
		ST_LOAD  = 4'b0100,
		ST_SEND  = 4'b1000
	} shcs_state_type;

	shcs_state_type  state;
	shcs_state_type  next_state;
	logic [2:0]      cur_area;
	logic [2:0]      next_cur_area;
	logic [5:0]      cur_index;
	logic [5:0]      next_cur_index;
	logic [7:0]      cur_left;
	logic [7:0]      next_cur_left;
	logic            next_cmd_ready;
	logic            next_rsp_valid;
	shcs_rsp_type    next_rsp;
	logic [2:0]      cmd_area;
	logic            cmd_fits;
	logic [16:0]     cmd_end;
	logic [15:0]     bank_data;

	// decode of the offered command
	always_comb
	begin
		cmd_area = shcs_area_of(CMD.code);
		cmd_end  = {1'b0, CMD.start} + {9'h000, CMD.count};
		cmd_fits = (CMD.count != 8'h00) && (cmd_end <= AREA_DEPTH);
	end

	// sequencer: a word is fetched only after the previous one left,
	// trading throughput for a bank with a single read port
	always_comb
	begin
		next_state     = state;
		next_cur_area  = cur_area;
		next_cur_index = cur_index;
		next_cur_left  = cur_left;
		next_rsp_valid = RSP_VALID;
		next_rsp       = RSP;
		case (state)
			ST_IDLE:
			begin
				if (CMD_VALID && CMD_READY)
				begin
					next_cur_area  = cmd_area;
					next_cur_index = CMD.start[5:0];
					next_cur_left  = CMD.count;
					if (cmd_area == AREA_NONE || !cmd_fits)
					begin
						// single error word, the bank word is not used
						next_rsp_valid = 1'b1;
						next_rsp.data  = ERROR_WORD;
						next_rsp.last  = 1'b1;
						next_rsp.error = 1'b1;
						next_state     = ST_SEND;
						next_cur_left  = COUNT_ONE;
					end
					else
						next_state = ST_FETCH;
				end
			end
			ST_FETCH:
				next_state = ST_LOAD;
			ST_LOAD:
			begin
				// bank word for cur_area/cur_index arrived this cycle
				next_rsp_valid = 1'b1;
				next_rsp.data  = bank_data;
				next_rsp.last  = (cur_left == COUNT_ONE);
				next_rsp.error = 1'b0;
				next_state     = ST_SEND;
			end
			ST_SEND:
			begin
				if (RSP_READY)
				begin
					next_rsp_valid = 1'b0;
					if (cur_left == COUNT_ONE)
						next_state = ST_IDLE;
					else
					begin
						next_cur_index = cur_index + 6'h01;
						next_cur_left  = cur_left - COUNT_ONE;
						next_state     = ST_FETCH;
					end
				end
			end
			default:
				next_state = ST_IDLE;
		endcase
		next_cmd_ready = (next_state == ST_IDLE);
	end

	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			state     <= ST_IDLE;
			cur_area  <= AREA_NONE;
			cur_index <= 6'h00;
			cur_left  <= 8'h00;
			CMD_READY <= 1'b1;
			RSP_VALID <= 1'b0;
			RSP       <= '0;
		end
		else
		begin
			state     <= next_state;
			cur_area  <= next_cur_area;
			cur_index <= next_cur_index;
			cur_left  <= next_cur_left;
			CMD_READY <= next_cmd_ready;
			RSP_VALID <= next_rsp_valid;
			RSP       <= next_rsp;
		end
	end

	// all seven areas share one bank; flags area holds one flag per word
	shcs_word_bank u_bank (
		.clk     (CLK_SYS),
		.resetn  (RESETN),
		.wr_en   (MEM_WR_EN),
		.wr_addr (shcs_word_addr(MEM_WR.area, MEM_WR.index)),
		.wr_data (MEM_WR.data),
		.rd_addr (shcs_word_addr(cur_area, cur_index)),
		.rd_data (bank_data)
	);

	// command taken with a valid range, for the area checks below
	logic cmd_good;
	assign cmd_good = CMD_VALID && CMD_READY && cmd_fits;

	a_core_io_read: assert property (
		@(posedge CLK_SYS) disable iff (!RESETN)
		cmd_good && CMD.code == CODE_READ_CORE_IO_WORDS
		|-> ##3 RSP_VALID && !RSP.error && cur_area == AREA_CORE_IO)
		else $error("core io read did not answer in three cycles");

	a_link_read: assert property (
		@(posedge CLK_SYS) disable iff (!RESETN)
		cmd_good && CMD.code == CODE_READ_LINK_WORDS
		|=> cur_area == AREA_LINK ##1 !RSP_VALID ##1 RSP_VALID)
		else $error("link read selected the wrong area or timing");

	a_holding_read: assert property (
		@(posedge CLK_SYS) disable iff (!RESETN)
		cmd_good && CMD.code == CODE_READ_HOLDING_WORDS
		|=> cur_area == AREA_HOLDING && cur_index == $past(CMD.start[5:0]))
		else $error("holding read start word not taken");

	a_present_read: assert property (
		@(posedge CLK_SYS) disable iff (!RESETN)
		cmd_good && CMD.code == CODE_READ_PRESENT_VALUES
		|=> cur_area == AREA_PRESENT && cur_left == $past(CMD.count))
		else $error("present value read count not taken");

	a_flags_read: assert property (
		@(posedge CLK_SYS) disable iff (!RESETN)
		cmd_good && CMD.code == CODE_READ_COMPLETION_FLAGS
		|=> !CMD_READY [*2] ##1 RSP_VALID && cur_area == AREA_FLAGS)
		else $error("completion flag read mis-sequenced");

	a_data_words: assert property (
		@(posedge CLK_SYS) disable iff (!RESETN)
		state == ST_LOAD && cur_area == AREA_DATA
		|=> RSP_VALID && RSP.data == $past(bank_data))
		else $error("data memory word not returned");

	a_aux_last: assert property (
		@(posedge CLK_SYS) disable iff (!RESETN)
		state == ST_LOAD && cur_area == AREA_AUXILIARY
		|=> RSP.last == ($past(cur_left) == COUNT_ONE))
		else $error("auxiliary read last flag wrong");

	a_unknown_code: assert property (
		@(posedge CLK_SYS) disable iff (!RESETN)
		CMD_VALID && CMD_READY && shcs_area_of(CMD.code) == AREA_NONE
		|=> RSP_VALID && RSP.error && RSP.last && RSP.data == ERROR_WORD)
		else $error("unknown code did not get an error word");

endmodule : shcs_server

// file: tb/shcs_sink.sv
// far-side model: the frame builder that drains response words.
// assumes one clock; it stalls at random so both prompt and slow
// acceptance are seen by the server.
`timescale 1ns/1ps
module shcs_sink
	import shcs_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// handshake toward the server
	output logic      rsp_ready
);
	integer seed = 32'h6b5f0f66;

	// ready changes only just after an edge, never mid-cycle
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rsp_ready <= 1'b0;
		else
			rsp_ready <= $random(seed) % 3 != 0;
	end
endmodule : shcs_sink

// file: tb/serial_host_command_server_tb.sv
// self-checking bench for the command server: fills the areas, then
// reads them back with every code and with refused commands.
// assumes the server answers in order, one command at a time.
`timescale 1ns/1ps
module serial_host_command_server_tb;
	import shcs_pkg::*;
	logic            clk_sys = 1'b0;
	logic            resetn = 1'b0;
	logic            cmd_valid = 1'b0;
	logic            cmd_ready;
	shcs_cmd_type    cmd = '0;
	logic            rsp_valid;
	logic            rsp_ready;
	shcs_rsp_type    rsp;
	logic            mem_wr_en = 1'b0;
	shcs_mem_wr_type mem_wr = '0;
	logic [15:0]     mem [0:6][0:63];
	logic [17:0]     exp_q [$];
	logic [15:0]     codes [0:6];
	integer          seed = 32'h6b5f0f66;
	integer          err_total = 0;
	integer          n_compared = 0;
	integer          cycles = 0;
	integer          k, s, i;
	logic [15:0]     w;

	shcs_server shcs_server_i (
		.CLK_SYS   (clk_sys),
		.RESETN    (resetn),
		.CMD_VALID (cmd_valid),
		.CMD_READY (cmd_ready),
		.CMD       (cmd),
		.RSP_VALID (rsp_valid),
		.RSP_READY (rsp_ready),
		.RSP       (rsp),
		.MEM_WR_EN (mem_wr_en),
		.MEM_WR    (mem_wr)
	);

	shcs_sink shcs_sink_i (
		.clk       (clk_sys),
		.resetn    (resetn),
		.rsp_ready (rsp_ready)
	);

	initial
	begin
		forever #5 clk_sys = ~clk_sys;
	end

	task check(input logic [17:0] seen, input logic [17:0] want);
		n_compared = n_compared + 1;
		if (seen !== want)
		begin
			err_total = err_total + 1;
			$display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check

	task give_verdict;
		if (err_total == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	// a hang ends the run as a failure
	always @(posedge clk_sys)
	begin
		cycles = cycles + 1;
		if (cycles == 60000)
		begin
			err_total = err_total + 1;
			give_verdict();
		end
	end

	// every accepted word is compared with the model, in order
	always @(posedge clk_sys)
	begin
		if (resetn && rsp_valid === 1'b1 && rsp_ready)
		begin
			if (exp_q.size() == 0)
				check(rsp, 18'h3FFFF);
			else
				check(rsp, exp_q.pop_front());
		end
	end

	// one area word written by the core side, mirrored in the model
	task put_word(input integer a, input integer x, input logic [15:0] d);
		@(posedge clk_sys);
		mem_wr_en <= 1'b1;
		mem_wr <= '{area: a[2:0], index: x[5:0], data: d};
		mem[a][x] = d;
		@(posedge clk_sys);
		mem_wr_en <= 1'b0;
	endtask : put_word

	// queue the expected words, offer one command, wait for the answer
	task send(input logic [15:0] c, input integer a, input integer st,
		input integer n);
		integer j;
		if (a > 6 || n == 0 || st + n > 64)
			exp_q.push_back({ERROR_WORD, 1'b1, 1'b1});
		else
			for (j = 0; j < n; j++)
				exp_q.push_back({mem[a][st + j], j == n - 1, 1'b0});
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd <= '{code: c, start: st[15:0], count: n[7:0]};
		forever
		begin
			@(posedge clk_sys);
			if (cmd_ready === 1'b1)
				break;
		end
		cmd_valid <= 1'b0;
		while (exp_q.size() != 0)
			@(posedge clk_sys);
	endtask : send

	initial
	begin
		codes = '{CODE_READ_CORE_IO_WORDS, CODE_READ_LINK_WORDS,
			CODE_READ_HOLDING_WORDS, CODE_READ_PRESENT_VALUES,
			CODE_READ_COMPLETION_FLAGS, CODE_READ_DATA_WORDS,
			CODE_READ_AUXILIARY_WORDS};
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		// fill every area with random words
		for (k = 0; k < 7; k++)
			for (i = 0; i < 64; i++)
			begin
				w = 16'($random(seed));
				put_word(k, i, w);
			end
		// each code: random span, the last word alone, back to back
		for (k = 0; k < 7; k++)
		begin
			s = {$random(seed)} % 64;
			send(codes[k], k, s, 1 + {$random(seed)} % (64 - s));
			send(codes[k], k, 63, 1);
		end
		send(codes[5], 5, 0, 64);
		// refused commands, then a read showing nothing was disturbed
		send(16'h5A5A, 7, 0, 1);
		send(codes[0], 0, 4, 0);
		send(codes[2], 2, 60, 5);
		send(codes[0], 0, 0, 64);
		// a word rewritten between commands is seen by the next read
		put_word(3, 10, 16'hA55A);
		send(codes[3], 3, 8, 4);
		// start word far beyond the area is refused like an overrun
		send(codes[1], 1, 256, 1);
		// reset in mid-run: outputs go idle, the bank keeps its words
		@(posedge clk_sys);
		resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check({16'h0000, cmd_ready, rsp_valid}, 18'h00002);
		check(rsp, 18'h00000);
		resetn <= 1'b1;
		send(codes[6], 6, 61, 3);
		give_verdict();
	end
endmodule : serial_host_command_server_tb
